// [pcsi_pkg.sv]
// Constants shared by the calibration status and interrupt enable block.
package pcsi_pkg;
  localparam logic [7:0] TRIM_STATUS_ADDR  = 8'hdc;
  localparam logic [7:0] IRQ_ENABLE_ADDR   = 8'hdd;
  localparam logic [7:0] TRIM_STATUS_RST   = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST    = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_WMASK  = 8'h6c;
  localparam int         CALIB_DONE_BIT    = 0;
  localparam int         OFFSET_ADJ_BIT    = 2;
  localparam int         PSAT_EN_BIT       = 6;
  localparam int         PROX_EN_BIT       = 5;
  localparam int         CALIB_EN_BIT      = 3;
  localparam int         ZERO_EN_BIT       = 2;
  localparam logic [6:0] I2C_DEV_ADDR      = 7'h29;
  localparam logic [3:0] I2C_BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    PCSI_IDLE    = 3'b000,
    PCSI_ADDR    = 3'b001,
    PCSI_ADDR_AK = 3'b010,
    PCSI_WR_BYTE = 3'b011,
    PCSI_WR_AK   = 3'b100,
    PCSI_RD_BYTE = 3'b101,
    PCSI_RD_AK   = 3'b110
  } pcsi_state_e;
endpackage

// [pcsi_i2c_slave.sv]
// Serial register port: byte-wide register access from the two-wire bus.
module pcsi_i2c_slave
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_oe,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rd_data
);
  import pcsi_pkg::*;
  pcsi_state_e state;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       first;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;

  assign start = scl & scl_q & sda_q & ~sda_in;
  assign stop  = scl & scl_q & ~sda_q & sda_in;
  assign rise  = scl & ~scl_q;
  assign fall  = ~scl & scl_q;
  assign wr_data = shreg;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Data is sampled on the rising clock edge and driven after the falling one.
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= PCSI_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      first    <= 1'b0;
      sda_oe   <= 1'b0;
      reg_addr <= 8'h00;
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start) begin
        state   <= PCSI_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop) begin
        state  <= PCSI_IDLE;
        sda_oe <= 1'b0;
      end else if (rise) begin
        case (state)
          PCSI_ADDR, PCSI_WR_BYTE: begin
            shreg   <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end
          PCSI_RD_BYTE: bit_cnt <= bit_cnt + 4'h1;
          PCSI_RD_AK: begin
            reg_addr <= reg_addr + 8'h01;
            if (sda_in) state <= PCSI_IDLE;
          end
          default: ;
        endcase
      end else if (fall) begin
        case (state)
          PCSI_ADDR: begin
            if (bit_cnt == I2C_BITS_PER_BYTE) begin
              if (shreg[7:1] == I2C_DEV_ADDR) begin
                state  <= PCSI_ADDR_AK;
                sda_oe <= 1'b1;
              end else begin
                state <= PCSI_IDLE;
              end
            end
          end
          PCSI_ADDR_AK: begin
            bit_cnt <= 4'h0;
            if (shreg[0]) begin
              state  <= PCSI_RD_BYTE;
              shreg  <= rd_data;
              sda_oe <= ~rd_data[7];
              rd_stb <= 1'b1;
            end else begin
              state  <= PCSI_WR_BYTE;
              sda_oe <= 1'b0;
              first  <= 1'b1;
            end
          end
          PCSI_WR_BYTE: begin
            if (bit_cnt == I2C_BITS_PER_BYTE) begin
              state  <= PCSI_WR_AK;
              sda_oe <= 1'b1;
              wr_stb <= ~first;
              if (first) reg_addr <= shreg;
            end
          end
          PCSI_WR_AK: begin
            state   <= PCSI_WR_BYTE;
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            if (!first) reg_addr <= reg_addr + 8'h01;
            first <= 1'b0;
          end
          PCSI_RD_BYTE: begin
            if (bit_cnt == I2C_BITS_PER_BYTE) begin
              state  <= PCSI_RD_AK;
              sda_oe <= 1'b0;
            end else begin
              shreg  <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
          PCSI_RD_AK: begin
            state   <= PCSI_RD_BYTE;
            bit_cnt <= 4'h0;
            shreg   <= rd_data;
            sda_oe  <= ~rd_data[7];
            rd_stb  <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // pcsi_i2c_slave

// [pcsi_top.sv]
// Calibration status flags, interrupt enable mask and interrupt pin.
module pcsi_top
(
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  input  wire logic CAL_DONE,
  input  wire logic PROX_VALID,
  input  wire logic PROX_ZERO,
  input  wire logic AUTO_OFFSET_EN,
  input  wire logic PSAT_EVENT,
  input  wire logic PROX_EVENT,
  output logic      OFFSET_DEC,
  output logic      INT_N_OUT,
  output logic      INT_OE
);
  import pcsi_pkg::*;
  logic [7:0] reg_addr;
  logic [7:0] wr_data;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rd_data;
  logic       calib_finished;
  logic       offset_adjusted;
  logic [7:0] irq_enable_mask;
  logic       zero_hit;
  logic       calib_clr;
  logic       adj_clr;
  logic       next_irq;

  pcsi_i2c_slave u_port (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .scl      (SCL_IN),
    .sda_in   (SDA_IN),
    .sda_oe   (SDA_OE),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .rd_data  (rd_data)
  );

  // The pin is open drain, so only the enable toggles.
  assign SDA_OUT   = 1'b0;
  assign INT_N_OUT = 1'b0;

  assign zero_hit  = PROX_VALID & PROX_ZERO & AUTO_OFFSET_EN;
  assign calib_clr = wr_stb && reg_addr == TRIM_STATUS_ADDR
                     && wr_data[CALIB_DONE_BIT];
  // The adjusted flag clears itself once its byte has been fetched.
  assign adj_clr   = rd_stb && reg_addr == TRIM_STATUS_ADDR;

  always_comb begin
    if (reg_addr == TRIM_STATUS_ADDR) begin
      rd_data = TRIM_STATUS_RST;
      rd_data[CALIB_DONE_BIT] = calib_finished;
      rd_data[OFFSET_ADJ_BIT] = offset_adjusted;
    end else if (reg_addr == IRQ_ENABLE_ADDR) begin
      rd_data = irq_enable_mask;
    end else begin
      rd_data = 8'h00;
    end
  end

  // A completion arriving with a clear keeps the flag set.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      calib_finished <= TRIM_STATUS_RST[CALIB_DONE_BIT];
    end else if (CAL_DONE) begin
      calib_finished <= 1'b1;
    end else if (calib_clr) begin
      calib_finished <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      offset_adjusted <= TRIM_STATUS_RST[OFFSET_ADJ_BIT];
      OFFSET_DEC      <= 1'b0;
    end else begin
      OFFSET_DEC <= zero_hit;
      if (zero_hit) begin
        offset_adjusted <= 1'b1;
      end else if (adj_clr) begin
        offset_adjusted <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      irq_enable_mask <= IRQ_ENABLE_RST;
    end else if (wr_stb && reg_addr == IRQ_ENABLE_ADDR) begin
      irq_enable_mask <= wr_data & IRQ_ENABLE_WMASK;
    end
  end

  always_comb begin
    next_irq = (calib_finished & irq_enable_mask[CALIB_EN_BIT])
             | (offset_adjusted & irq_enable_mask[ZERO_EN_BIT])
             | (PSAT_EVENT & irq_enable_mask[PSAT_EN_BIT])
             | (PROX_EVENT & irq_enable_mask[PROX_EN_BIT]);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      INT_OE <= 1'b0;
    end else begin
      INT_OE <= next_irq;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  property p_calib_set;
    CAL_DONE |=> calib_finished && rd_data[CALIB_DONE_BIT] ||
                 reg_addr != TRIM_STATUS_ADDR;
  endproperty
  a_calib_set: assert property (p_calib_set)
    else $error("calibration flag did not set");

  property p_calib_hold;
    calib_finished && !calib_clr |=> calib_finished;
  endproperty
  a_calib_hold: assert property (p_calib_hold)
    else $error("calibration flag lost without a one written");

  property p_calib_clear;
    calib_clr && !CAL_DONE |=> !calib_finished;
  endproperty
  a_calib_clear: assert property (p_calib_clear)
    else $error("calibration flag not cleared by write of one");

  property p_calib_irq;
    calib_finished && irq_enable_mask[CALIB_EN_BIT] |=> INT_OE;
  endproperty
  a_calib_irq: assert property (p_calib_irq)
    else $error("calibration interrupt missing");

  property p_adjust;
    zero_hit |=> OFFSET_DEC && offset_adjusted ##1 !OFFSET_DEC || zero_hit;
  endproperty
  a_adjust: assert property (p_adjust)
    else $error("zero result did not adjust the offset");

  property p_adjust_flag;
    !offset_adjusted ##1 offset_adjusted |-> $past(zero_hit);
  endproperty
  a_adjust_flag: assert property (p_adjust_flag)
    else $error("adjusted flag set without an adjustment");

  property p_psat_irq;
    PSAT_EVENT && irq_enable_mask[PSAT_EN_BIT] |=> INT_OE;
  endproperty
  a_psat_irq: assert property (p_psat_irq)
    else $error("saturation interrupt missing");

  property p_prox_irq;
    PROX_EVENT && irq_enable_mask[PROX_EN_BIT] |=> INT_OE;
  endproperty
  a_prox_irq: assert property (p_prox_irq)
    else $error("proximity interrupt missing");

  property p_zero_irq;
    offset_adjusted && irq_enable_mask[ZERO_EN_BIT] |=> INT_OE;
  endproperty
  a_zero_irq: assert property (p_zero_irq)
    else $error("zero detect interrupt missing");

  property p_enable_reset;
    @(posedge SYS_CLK) $past(RESET) |-> irq_enable_mask == IRQ_ENABLE_RST;
  endproperty
  a_enable_reset: assert property (p_enable_reset)
    else $error("enable mask not zero after reset");

  property p_irq_level;
    INT_OE == $past(next_irq) && !INT_N_OUT;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin does not follow enabled flags");

  property p_no_dec;
    !zero_hit |=> !OFFSET_DEC;
  endproperty
  a_no_dec: assert property (p_no_dec)
    else $error("offset decrement without a zero result");

  property p_adj_clear;
    adj_clr && !zero_hit |=> !offset_adjusted;
  endproperty
  a_adj_clear: assert property (p_adj_clear)
    else $error("adjusted flag not cleared after its fetch");

  property p_mask_write;
    wr_stb && reg_addr == IRQ_ENABLE_ADDR
      |=> irq_enable_mask == ($past(wr_data) & IRQ_ENABLE_WMASK);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("enable mask write did not land");

  property p_mask_hold;
    !(wr_stb && reg_addr == IRQ_ENABLE_ADDR) |=> $stable(irq_enable_mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("enable mask changed without a write");

  property p_mask_reserved;
    (irq_enable_mask & ~IRQ_ENABLE_WMASK) == 8'h00;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved enable bit is set");

  property p_irq_release;
    !calib_finished && !offset_adjusted && !PSAT_EVENT && !PROX_EVENT
      |=> !INT_OE;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt held with no flag set");

  c_cal_irq: cover property (CAL_DONE ##[1:20] INT_OE);
  c_clear:   cover property (calib_finished ##1 calib_clr ##1 !calib_finished);
  c_adjust:  cover property (zero_hit ##[1:500] adj_clr);
  c_mask_wr: cover property (wr_stb && reg_addr == IRQ_ENABLE_ADDR);
endmodule // pcsi_top

// [pcsi_host_model.sv]
// Bus host model that runs register transfers on the two-wire serial bus.
module pcsi_host_model
(
  input  wire logic clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcsi_pkg::*;
  int ack_err = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Each bus phase lasts five system clocks so the device sees it settle.
  task automatic put_bit(input logic b);
    scl = 1'b0;
    tick(2);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(5);
  endtask
  // The data line is released here, so the device or, when it does not drive, the pull-up decides its level.
  task automatic get_bit(output logic b);
    scl = 1'b0;
    tick(2);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    b = sda;
    tick(2);
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(a);
    if (a !== 1'b0) begin
      ack_err++;
    end
  endtask
  task automatic start_cond();
    scl = 1'b0;
    tick(2);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_low = 1'b1;
    tick(5);
  endtask
  task automatic stop_cond();
    scl = 1'b0;
    tick(2);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_low = 1'b0;
    tick(5);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start_cond();
    put_byte({I2C_DEV_ADDR, 1'b0});
    put_byte(a);
    put_byte(d);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic b;
    start_cond();
    put_byte({I2C_DEV_ADDR, 1'b0});
    put_byte(a);
    start_cond();
    put_byte({I2C_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
    stop_cond();
  endtask
endmodule // pcsi_host_model

// [pcsi_top_test.sv]
// Self-checking bench for the calibration status and interrupt enable block.
module pcsi_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pcsi_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, cal_done = 1'b0, prox_valid = 1'b0;
  logic prox_zero = 1'b0, auto_en = 1'b0, psat = 1'b0, prox = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, offset_dec, int_n, int_oe;
  logic [7:0] rd;
  int fails = 0, total_checks = 0;
  wire logic sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  pcsi_top i_pcsi_top (.SYS_CLK(sys_clk), .RESET(reset), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CAL_DONE(cal_done),
    .PROX_VALID(prox_valid), .PROX_ZERO(prox_zero), .AUTO_OFFSET_EN(auto_en),
    .PSAT_EVENT(psat), .PROX_EVENT(prox), .OFFSET_DEC(offset_dec),
    .INT_N_OUT(int_n), .INT_OE(int_oe));
  pcsi_host_model i_pcsi_host_model (.clk(sys_clk), .scl(scl),
    .sda_low(sda_low), .sda(sda));
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pcsi_host_model.write_reg(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_pcsi_host_model.read_reg(a, rd);
    chk_byte(rd, exp);
  endtask
  task automatic pulse_prox();
    prox_valid = 1'b1;
    cyc(1);
    prox_valid = 1'b0;
  endtask
  task automatic t_reset_values();
    rd_chk(TRIM_STATUS_ADDR, 8'h00);
    rd_chk(IRQ_ENABLE_ADDR, 8'h00);
    chk_pin(int_oe, 1'b0);
    chk_pin(int_n, 1'b0);
    wr(IRQ_ENABLE_ADDR, 8'hff);
    rd_chk(IRQ_ENABLE_ADDR, 8'h6c);
    rd_chk(8'hc0, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h00);
  endtask
  task automatic t_calib_done();
    cal_done = 1'b1;
    cyc(1);
    cal_done = 1'b0;
    cyc(2);
    chk_pin(int_oe, 1'b0);
    rd_chk(TRIM_STATUS_ADDR, 8'h01);
    wr(IRQ_ENABLE_ADDR, 8'h08);
    cyc(2);
    chk_pin(int_oe, 1'b1);
    wr(TRIM_STATUS_ADDR, 8'h00);
    rd_chk(TRIM_STATUS_ADDR, 8'h01);
    wr(TRIM_STATUS_ADDR, 8'h01);
    cyc(2);
    chk_pin(int_oe, 1'b0);
    rd_chk(TRIM_STATUS_ADDR, 8'h00);
  endtask
  task automatic t_offset_adjust();
    wr(IRQ_ENABLE_ADDR, 8'h04);
    prox_zero = 1'b1;
    pulse_prox();
    chk_pin(offset_dec, 1'b0);
    auto_en = 1'b1;
    pulse_prox();
    chk_pin(offset_dec, 1'b1);
    cyc(1);
    chk_pin(offset_dec, 1'b0);
    chk_pin(int_oe, 1'b1);
    rd_chk(TRIM_STATUS_ADDR, 8'h04);
    rd_chk(TRIM_STATUS_ADDR, 8'h00);
    chk_pin(int_oe, 1'b0);
    prox_zero = 1'b0;
    pulse_prox();
    chk_pin(offset_dec, 1'b0);
    auto_en = 1'b0;
    wr(IRQ_ENABLE_ADDR, 8'h00);
  endtask
  // Each level event is checked with its own enable and with the other one.
  task automatic t_level_events();
    for (int i = 0; i < 2; i++) begin
      psat = (i == 0);
      prox = (i == 1);
      cyc(2);
      chk_pin(int_oe, 1'b0);
      wr(IRQ_ENABLE_ADDR, (i == 0) ? 8'h40 : 8'h20);
      cyc(2);
      chk_pin(int_oe, 1'b1);
      wr(IRQ_ENABLE_ADDR, (i == 0) ? 8'h20 : 8'h40);
      cyc(2);
      chk_pin(int_oe, 1'b0);
      wr(IRQ_ENABLE_ADDR, 8'h00);
    end
    psat = 1'b0;
    prox = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    $display("wrong value at %0t: run timed out", $time);
    complete_run();
  end
  initial begin
    cyc(3);
    reset = 1'b0;
    cyc(2);
    t_reset_values();
    t_calib_done();
    t_offset_adjust();
    t_level_events();
    chk_byte(i_pcsi_host_model.ack_err[7:0], 8'h00);
    complete_run();
  end
endmodule // pcsi_top_test
